// >>> core/twsio_cfg.svh
// Constants of the three-wire serial port: addresses, field positions, resets, counts
`ifndef TWSIO_CFG_SVH
`define TWSIO_CFG_SVH

`define TWSIO_MODE_ADDR       16'hff72
`define TWSIO_SHIFT_ADDR      16'hff70
`define TWSIO_MODE_RESET      8'h00
`define TWSIO_MODE_WMASK      8'h96
`define TWSIO_ENABLE_POS      7
`define TWSIO_COUNT_SEL_POS   4
`define TWSIO_FIRST_BIT_POS   2
`define TWSIO_CLK_SRC_POS     1
`define TWSIO_HALF_DIV4       3'd1
`define TWSIO_HALF_DIV8       3'd3
`define TWSIO_LAST_BIT        3'd7
`define TWSIO_FIFO_WIDTH      8
`define TWSIO_FIFO_DEPTH      8
`define TWSIO_IRQ_PRIORITY    4'h7
`define TWSIO_IRQ_VECTOR      16'h0012

`endif

// >>> core/twsio_pkg.sv
// Types shared by the three-wire serial port files
package twsio_pkg;

  typedef enum logic [1:0]
  {
    TWSIO_IDLE  = 2'b00,
    TWSIO_SHIFT = 2'b01,
    TWSIO_DONE  = 2'b11
  } twsio_state_t;

  typedef struct packed
  {
    logic        enable;
    logic        count_sel;
    logic        first_lsb;
    logic        clk_internal;
  } twsio_mode_t;

  typedef struct packed
  {
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic        bit_op;
    logic [2:0]  bit_idx;
    logic [7:0]  wdata;
  } twsio_bus_t;

  typedef struct packed
  {
    twsio_state_t state;
    logic [7:0]   mode;
    logic [7:0]   shreg;
    logic         so;
    logic         sck;
    logic         sck_prev;
    logic [2:0]   div;
    logic [2:0]   bits;
    logic         irq;
    logic [7:0]   rdata;
  } twsio_regs_t;

endpackage

// >>> core/twsio_fifo.sv
// Receive FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module twsio_fifo
  import twsio_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
)
(
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed
  {
    logic [AW:0] wptr;
    logic [AW:0] rptr;
  } twsio_fifo_regs_t;

  twsio_fifo_regs_t s_q;
  twsio_fifo_regs_t s_d;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  assign full          = (s_q.wptr[AW] != s_q.rptr[AW]) && (s_q.wptr[AW-1:0] == s_q.rptr[AW-1:0]);
  assign empty         = (s_q.wptr == s_q.rptr);
  assign in_ready_out  = !full;
  assign out_valid_out = !empty;
  assign out_data_out  = mem_q[s_q.rptr[AW-1:0]];
  assign push          = in_valid_in && !full;
  assign pop           = out_ready_in && !empty;

  always_comb
  begin
    s_d = s_q;
    if (push)
    begin
      s_d.wptr = s_q.wptr + 1'b1;
    end
    if (pop)
    begin
      s_d.rptr = s_q.rptr + 1'b1;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Storage needs no reset; empty flag guards stale words
  always_ff @(posedge clk_in)
  begin
    if (push)
    begin
      mem_q[s_q.wptr[AW-1:0]] <= in_data_in;
    end
  end

endmodule

`default_nettype wire

// >>> core/twsio_core.sv
// Three-wire serial port: mode register, shift engine, receive buffering
`timescale 1ns/1ps
`default_nettype none
`include "twsio_cfg.svh"

module twsio_core
  import twsio_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [15:0] bus_addr_in,
  input  wire logic        bus_wr_in,
  input  wire logic        bus_rd_in,
  input  wire logic        bus_bit_op_in,
  input  wire logic [2:0]  bus_bit_idx_in,
  input  wire logic [7:0]  bus_wdata_in,
  output logic      [7:0]  bus_rdata_out,
  input  wire logic        serial_clock_pin_in,
  output logic             serial_clock_pin_out,
  output logic             serial_clock_pin_oe_n_out,
  output logic             serial_out_pin_out,
  input  wire logic        serial_in_pin_in,
  output logic             transfer_done_irq_out,
  output logic      [3:0]  irq_priority_out,
  output logic      [15:0] irq_vector_out,
  output logic             busy_out,
  output logic             rx_valid_out,
  input  wire logic        rx_ready_in,
  output logic      [7:0]  rx_data_out
);

  twsio_regs_t s_q;
  twsio_regs_t s_d;
  twsio_bus_t  bus;
  twsio_mode_t mode;
  logic        fifo_ready;
  logic        fifo_push;
  logic        mode_sel;
  logic        shift_sel;

  // Falling edge: next bit to the output latch, register moves one place
  function automatic logic [8:0] shift_out(input logic [7:0] sh, input logic lsb_first);
    logic [8:0] r;
    r = '0;
    if (lsb_first)
    begin
      r = {sh[0], sh[7], sh[7:1]};
    end
    else
    begin
      r = {sh[7], sh[6:0], sh[0]};
    end
    return r;
  endfunction

  // Rising edge: serial input fills the vacated end
  function automatic logic [7:0] sample_in(input logic [7:0] sh, input logic lsb_first,
                                           input logic si);
    logic [7:0] r;
    r = sh;
    if (lsb_first)
    begin
      r[7] = si;
    end
    else
    begin
      r[0] = si;
    end
    return r;
  endfunction

  // Address match shared by the read, write and start paths
  function automatic logic is_reg(input logic [15:0] a, input logic [15:0] reg_addr);
    logic hit;
    hit = (a == reg_addr);
    return hit;
  endfunction

  // Pin edge from the previous and the present sample
  function automatic logic pin_edge(input logic prev, input logic cur, input logic rising);
    logic e;
    e = rising ? (!prev && cur) : (prev && !cur);
    return e;
  endfunction

  assign bus = '{addr: bus_addr_in, wr: bus_wr_in, rd: bus_rd_in, bit_op: bus_bit_op_in,
                 bit_idx: bus_bit_idx_in, wdata: bus_wdata_in};

  assign mode.enable       = s_q.mode[`TWSIO_ENABLE_POS];
  assign mode.count_sel    = s_q.mode[`TWSIO_COUNT_SEL_POS];
  assign mode.first_lsb    = s_q.mode[`TWSIO_FIRST_BIT_POS];
  assign mode.clk_internal = s_q.mode[`TWSIO_CLK_SRC_POS];

  assign mode_sel  = is_reg(bus.addr, `TWSIO_MODE_ADDR);
  assign shift_sel = is_reg(bus.addr, `TWSIO_SHIFT_ADDR);

  always_comb
  begin
    logic [8:0] so_sh;
    logic [2:0] half;
    logic       fall;
    logic       rise;
    logic       ext_fall;
    logic       ext_rise;
    so_sh    = '0;
    half     = mode.count_sel ? `TWSIO_HALF_DIV8 : `TWSIO_HALF_DIV4;
    fall     = 1'b0;
    rise     = 1'b0;
    // An outside clock edge is found against the pin sample of one cycle before, so each level must last one clock
    ext_fall = pin_edge(s_q.sck_prev, serial_clock_pin_in, 1'b0);
    ext_rise = pin_edge(s_q.sck_prev, serial_clock_pin_in, 1'b1);
    s_d          = s_q;
    s_d.irq      = 1'b0;
    s_d.sck_prev = serial_clock_pin_in;

    // Register reads answer one cycle later from a flip-flop
    if (bus.rd)
    begin
      if (mode_sel)
      begin
        s_d.rdata = bus.bit_op ? {7'h00, s_q.mode[bus.bit_idx]} : s_q.mode;
      end
      else if (shift_sel)
      begin
        s_d.rdata = s_q.shreg;
      end
      else
      begin
        s_d.rdata = 8'h00;
      end
    end

    // Mode writes; reserved bits stay zero whatever software writes
    if (bus.wr && mode_sel)
    begin
      if (bus.bit_op)
      begin
        s_d.mode[bus.bit_idx] = bus.wdata[0];
      end
      else
      begin
        s_d.mode = bus.wdata;
      end
      s_d.mode = s_d.mode & `TWSIO_MODE_WMASK;
    end

    unique case (s_q.state)
      TWSIO_IDLE:
      begin
        s_d.sck = 1'b1;
        s_d.div = 3'd0;
        // Only whole-byte writes load the shift register
        if (bus.wr && !bus.bit_op && shift_sel)
        begin
          s_d.shreg = bus.wdata;
          // A free buffer slot is needed at start so the done cycle can always push
          // A disabled write is stored but never armed for later
          if (mode.enable && fifo_ready &&
              (mode.clk_internal || serial_clock_pin_in))
          begin
            s_d.state = TWSIO_SHIFT;
            s_d.bits  = 3'd0;
          end
        end
      end
      TWSIO_SHIFT:
      begin
        // Shift register writes are not taken while shifting, which also freezes the
        // external-clock byte once loaded
        // Dropping the enable abandons the byte; nothing reaches the buffer
        if (!mode.enable)
        begin
          s_d.state = TWSIO_IDLE;
          s_d.sck   = 1'b1;
        end
        else
        begin
          if (mode.clk_internal)
          begin
            if (s_q.div == half)
            begin
              s_d.div = 3'd0;
              fall    = s_q.sck;
              rise    = !s_q.sck;
              s_d.sck = !s_q.sck;
            end
            else
            begin
              s_d.div = s_q.div + 3'd1;
            end
          end
          else
          begin
            fall = ext_fall;
            rise = ext_rise;
          end
          if (fall)
          begin
            so_sh     = shift_out(s_q.shreg, mode.first_lsb);
            s_d.so    = so_sh[8];
            s_d.shreg = so_sh[7:0];
          end
          if (rise)
          begin
            s_d.shreg = sample_in(s_q.shreg, mode.first_lsb, serial_in_pin_in);
            s_d.bits  = s_q.bits + 3'd1;
            if (s_q.bits == `TWSIO_LAST_BIT)
            begin
              s_d.state = TWSIO_DONE;
            end
          end
        end
      end
      TWSIO_DONE:
      begin
        // Received byte goes to the buffer in this cycle; room was checked at start
        s_d.irq   = 1'b1;
        s_d.state = TWSIO_IDLE;
      end
      // Unused state code falls back to idle
      default:
      begin
        s_d.state = TWSIO_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      s_q.state    <= TWSIO_IDLE;
      s_q.mode     <= `TWSIO_MODE_RESET;
      s_q.so       <= 1'b1;
      s_q.sck      <= 1'b1;
      s_q.sck_prev <= 1'b1;
      s_q.div      <= 3'd0;
      s_q.bits     <= 3'd0;
      s_q.irq      <= 1'b0;
      s_q.rdata    <= 8'h00;
      // Shift register content is left undefined by reset
      s_q.shreg    <= s_d.shreg;
    end
    else
    begin
      s_q.state    <= s_d.state;
      s_q.mode     <= s_d.mode;
      s_q.so       <= s_d.so;
      s_q.sck      <= s_d.sck;
      s_q.sck_prev <= s_d.sck_prev;
      s_q.div      <= s_d.div;
      s_q.bits     <= s_d.bits;
      s_q.irq      <= s_d.irq;
      s_q.rdata    <= s_d.rdata;
      s_q.shreg    <= s_d.shreg;
    end
  end

  assign fifo_push = (s_q.state == TWSIO_DONE);

  // Full buffer holds off new transfers instead of losing a received byte
  twsio_fifo #(
    .WIDTH (`TWSIO_FIFO_WIDTH),
    .DEPTH (`TWSIO_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (fifo_push),
    .in_ready_out  (fifo_ready),
    .in_data_in    (s_q.shreg),
    .out_valid_out (rx_valid_out),
    .out_ready_in  (rx_ready_in),
    .out_data_out  (rx_data_out)
  );

  assign bus_rdata_out             = s_q.rdata;
  assign serial_clock_pin_out      = s_q.sck;
  assign serial_clock_pin_oe_n_out = !(mode.enable && mode.clk_internal);
  assign serial_out_pin_out        = s_q.so;
  assign transfer_done_irq_out     = s_q.irq;
  assign irq_priority_out          = `TWSIO_IRQ_PRIORITY;
  assign irq_vector_out            = `TWSIO_IRQ_VECTOR;
  assign busy_out                  = (s_q.state != TWSIO_IDLE);

endmodule

`default_nettype wire

// >>> tb/twsio_monitor.sv
// Port-level checks for the three-wire serial port
`timescale 1ns/1ps
`default_nettype none

module twsio_monitor
  import twsio_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic [15:0] bus_addr_in,
  input wire logic        bus_wr_in,
  input wire logic        bus_rd_in,
  input wire logic        bus_bit_op_in,
  input wire logic [2:0]  bus_bit_idx_in,
  input wire logic [7:0]  bus_wdata_in,
  input wire logic [7:0]  bus_rdata_out,
  input wire logic        serial_clock_pin_out,
  input wire logic        serial_clock_pin_oe_n_out,
  input wire logic        serial_out_pin_out,
  input wire logic        transfer_done_irq_out,
  input wire logic [3:0]  irq_priority_out,
  input wire logic [15:0] irq_vector_out,
  input wire logic        busy_out
);
  localparam logic [7:0] MK = 8'h96;
  logic [7:0] m_q;
  logic [3:0] n_q;
  logic       mw;
  logic       ion;
  assign mw = bus_wr_in && bus_addr_in == 16'hff72;
  assign ion = m_q[7] && m_q[1];

  // Shadow of the mode register, reserved bits forced low
  always_ff @(posedge clk_in)
    if (rst_in)
      m_q <= 8'h00;
    else if (mw && bus_bit_op_in)
      m_q[bus_bit_idx_in] <= bus_wdata_in[0] & MK[bus_bit_idx_in];
    else if (mw)
      m_q <= bus_wdata_in & MK;

  // Falling clock edges seen within one transfer
  always_ff @(posedge clk_in)
    if (rst_in || !busy_out)
      n_q <= 4'h0;
    else if ($fell(serial_clock_pin_out))
      n_q <= n_q + 4'h1;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  property p_const;
    irq_priority_out == 4'h7 && irq_vector_out == 16'h0012;
  endproperty
  property p_pulse;
    transfer_done_irq_out |=> !transfer_done_irq_out;
  endproperty
  property p_idle;
    !busy_out |-> serial_clock_pin_out;
  endproperty
  property p_so;
    $changed(serial_out_pin_out) && busy_out && ion |-> !serial_clock_pin_out;
  endproperty
  property p_half;
    $fell(serial_clock_pin_out) |-> !serial_clock_pin_out [*2] ##[1:3] serial_clock_pin_out;
  endproperty
  property p_oe;
    serial_clock_pin_oe_n_out == !ion;
  endproperty
  property p_rd;
    bus_rd_in && bus_addr_in == 16'hff72 && !bus_bit_op_in |=> bus_rdata_out == $past(m_q);
  endproperty
  property p_span;
    $rose(busy_out) && !serial_clock_pin_oe_n_out |-> ##[30:72] transfer_done_irq_out;
  endproperty
  property p_eight;
    transfer_done_irq_out && ion |-> n_q == 4'h8;
  endproperty
  property p_off;
    bus_wr_in && bus_addr_in == 16'hff70 && !m_q[7] |=> !busy_out;
  endproperty

  a_const: assert property (p_const) else $error("priority or vector wrong");
  a_pulse: assert property (p_pulse) else $error("done pulse too long");
  a_idle: assert property (p_idle) else $error("clock not idle high");
  a_so: assert property (p_so) else $error("data moved off falling edge");
  a_half: assert property (p_half) else $error("low half period wrong");
  a_oe: assert property (p_oe) else $error("clock pin driven");
  a_rd: assert property (p_rd) else $error("mode read wrong");
  a_span: assert property (p_span) else $error("transfer not ended");
  a_eight: assert property (p_eight) else $error("clock count not eight");
  a_off: assert property (p_off) else $error("disabled start");

  c_done: cover property (transfer_done_irq_out && ion);
  c_ext: cover property (busy_out && serial_clock_pin_oe_n_out);
  c_lsb: cover property (transfer_done_irq_out && m_q[2]);
endmodule

bind twsio_core twsio_monitor mon (.clk_in, .rst_in, .bus_addr_in, .bus_wr_in, .bus_rd_in,
  .bus_bit_op_in, .bus_bit_idx_in, .bus_wdata_in, .bus_rdata_out, .serial_clock_pin_out,
  .serial_clock_pin_oe_n_out, .serial_out_pin_out, .transfer_done_irq_out,
  .irq_priority_out, .irq_vector_out, .busy_out);

`default_nettype wire

// >>> tb/twsio_peer.sv
// Peripheral model at the far end of the serial link
`timescale 1ns/1ps
`default_nettype none

module twsio_peer
(
  input  wire logic clk_in,
  input  wire logic sck_in,
  input  wire logic so_in,
  output logic      si_out,
  output logic      ext_sck_out
);
  logic [7:0] tx_q;
  logic [7:0] rx_q;

  initial
  begin
    si_out = 1'b1;
    ext_sck_out = 1'b1; // Idles high
    tx_q = 8'h00;
    rx_q = 8'h00;
  end

  // Rotating, so the byte is intact after eight bits
  always @(negedge sck_in)
  begin
    si_out <= tx_q[7];
    tx_q <= {tx_q[6:0], tx_q[7]};
  end

  always @(posedge sck_in)
    rx_q <= {rx_q[6:0], so_in};

  // Master clock: eight edge pairs, levels long enough for the pin sampler
  task automatic burst(input int half);
    repeat (8)
    begin
      repeat (half) @(negedge clk_in);
      ext_sck_out = 1'b0;
      repeat (half) @(negedge clk_in);
      ext_sck_out = 1'b1;
    end
  endtask
endmodule

`default_nettype wire

// >>> tb/twsio_core_tb.sv
// Self-checking bench for the three-wire serial port
`timescale 1ns/1ps
`default_nettype none

module twsio_core_tb;
  import twsio_pkg::*;
  localparam logic [15:0] MA = 16'hff72;
  localparam logic [15:0] SA = 16'hff70;
  logic        clk_in, rst_in, wr, rd, bop, sck_o, oe_n, so, si, irq, busy;
  logic        rxv, rxr, ext, hold;
  logic [15:0] addr;
  logic [2:0]  bidx;
  logic [7:0]  wd, rdat, rxd, d, p;
  logic [7:0]  exp_q[$];
  logic [7:0]  modes[4] = '{8'h82, 8'h92, 8'h86, 8'h96};
  int          failures, total_checks, seed, k;
  wire         pin = oe_n ? ext : sck_o; // Pin level from both drivers

  twsio_core uut (.clk_in, .rst_in, .bus_addr_in(addr), .bus_wr_in(wr), .bus_rd_in(rd),
    .bus_bit_op_in(bop), .bus_bit_idx_in(bidx), .bus_wdata_in(wd), .bus_rdata_out(rdat),
    .serial_clock_pin_in(pin), .serial_clock_pin_out(sck_o), .serial_clock_pin_oe_n_out(oe_n),
    .serial_out_pin_out(so), .serial_in_pin_in(si), .transfer_done_irq_out(irq),
    .irq_priority_out(), .irq_vector_out(), .busy_out(busy), .rx_valid_out(rxv),
    .rx_ready_in(rxr), .rx_data_out(rxd));
  twsio_peer peer (.clk_in, .sck_in(pin), .so_in(so), .si_out(si), .ext_sck_out(ext));

  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  function automatic logic [7:0] rev(input logic [7:0] v);
    return {<<{v}};
  endfunction

  task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic close_out;
    if (failures == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // One access; read data is settled at the negedge after the strobe
  task automatic bus(input logic w, input logic [15:0] a, input logic b, input logic [2:0] i,
                     input logic [7:0] v);
    @(negedge clk_in);
    wr = w;
    rd = !w;
    addr = a;
    bop = b;
    bidx = i;
    wd = v;
    @(negedge clk_in);
    wr = 1'b0;
    rd = 1'b0;
  endtask

  task automatic wait_done;
    for (k = 0; k < 300 && irq !== 1'b1; k++)
      @(negedge clk_in);
    if (k == 300)
    begin
      failures++;
      close_out;
    end
  endtask

  task automatic xfer(input logic [7:0] m);
    d = 8'($random(seed));
    p = 8'($random(seed));
    peer.tx_q = p;
    bus(1'b1, MA, 1'b0, 3'd0, m);
    bus(1'b1, SA, 1'b0, 3'd0, d);
    exp_q.push_back(m[2] ? rev(p) : p);
    if (!m[1])
      bus(1'b1, SA, 1'b0, 3'd0, ~d);
    fork
      if (!m[1])
        peer.burst(4);
      wait_done;
    join
    cmp("peer byte", m[2] ? rev(d) : d, peer.rx_q);
  endtask

  // Sink stalls at random; received bytes checked in order
  always @(negedge clk_in)
    rxr <= hold ? 1'b0 : 1'($random(seed));
  always @(posedge clk_in)
    if (rxv === 1'b1 && rxr === 1'b1)
      cmp("rx byte", exp_q.pop_front(), rxd);

  initial
  begin
    seed = 32'h9e20db87;
    failures = 0;
    total_checks = 0;
    hold = 1'b1;
    rxr = 1'b0;
    rst_in = 1'b1;
    {wr, rd, bop, bidx, wd, addr} = '0;
    repeat (4) @(negedge clk_in);
    rst_in = 1'b0;
    bus(1'b0, MA, 1'b0, 3'd0, 8'h00);
    cmp("mode", 8'h00, rdat);
    bus(1'b1, MA, 1'b1, 3'd4, 8'h01);
    bus(1'b0, MA, 1'b1, 3'd4, 8'h00);
    cmp("mode bit", 8'h01, rdat);
    bus(1'b0, MA, 1'b0, 3'd0, 8'h00);
    cmp("mode", 8'h10, rdat);
    bus(1'b0, 16'hff74, 1'b0, 3'd0, 8'h00);
    cmp("unmapped", 8'h00, rdat);
    bus(1'b1, MA, 1'b0, 3'd0, 8'h00);
    bus(1'b1, SA, 1'b0, 3'd0, 8'h5a);
    bus(1'b1, MA, 1'b0, 3'd0, 8'h82);
    repeat (8) @(negedge clk_in);
    cmp("busy", 8'h00, {7'h0, busy});
    for (int i = 0; i < 8; i++)
      xfer(modes[i % 4]);
    bus(1'b1, SA, 1'b0, 3'd0, 8'h3c);
    repeat (8) @(negedge clk_in);
    cmp("busy full", 8'h00, {7'h0, busy});
    bus(1'b1, MA, 1'b0, 3'd0, 8'h00);
    hold = 1'b0;
    // Let the sink drain before the buffer is needed again
    repeat (20) @(negedge clk_in);
    for (int i = 0; i < 8; i++)
      xfer(modes[i % 4]);
    xfer(8'h80);
    xfer(8'h84);
    repeat (80) @(negedge clk_in);
    cmp("left", 8'h00, 8'(exp_q.size()));
    close_out;
  end
endmodule

`default_nettype wire
